// ### pkg/ebw_pkg.sv
package ebw_pkg;
    // -------------------------------------------------------------
    // register map (word index, byte address = index * 4)
    // -------------------------------------------------------------
    localparam int N_EXT       = 4;
    localparam int N_INT       = 6;
    localparam int N_INT_LOW   = 4;
    localparam int N_REGS      = 21;
    localparam logic [5:0] REG_DEF    = 6'h00; // default_bus_config
    localparam logic [5:0] REG_WCFG   = 6'h01; // window_bus_config 1..4
    localparam logic [5:0] REG_ESEL   = 6'h05; // ext_window_select 1..4
    localparam logic [5:0] REG_ISEL   = 6'h09; // internal_window_select 1..6
    localparam logic [5:0] REG_ICFG   = 6'h0f; // internal_bus_config 1..6
    localparam logic [5:0] REG_STATUS = 6'h15; // sequencer status, read only
    localparam logic [15:0] CFG_WMASK = 16'hd7ff;
    localparam logic [15:0] SEL_WMASK = 16'hffff;
    localparam logic [15:0] RST_DEF_CFG = 16'h0600; // bus active, latch stretch
    localparam int BTYP_LSB   = 6;
    // -------------------------------------------------------------
    // decode and timing constants
    // -------------------------------------------------------------
    localparam logic [3:0] SIZE_MAX_EXT = 4'ha;
    localparam logic [3:0] SIZE_MAX_LOW = 4'hb;
    localparam logic [4:0] WAIT_TOP     = 5'h0f; // waits = 15 - field
    localparam logic [4:0] CMD_BASE     = 5'h01; // extra base command tcl
    localparam logic [3:0] WIN_DEF      = 4'h0;
    localparam logic [3:0] WIN_INT0     = 4'h5;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef enum logic [2:0] {
        PH_IDLE, PH_ALE, PH_ALEX, PH_DLY, PH_CMD, PH_TRI, PH_DONE
    } ebw_phase_t;

    typedef struct packed {
        logic       wr_gated;
        logic       rd_gated;
        logic       rsv13;
        logic       ready_en;
        logic       rsv11;
        logic       bus_active;
        logic       ale_stretch;
        logic       early_wr;
        logic [1:0] bus_type;
        logic       tri_ctl;
        logic       cmd_dly;
        logic [3:0] cycle_wait;
    } ebw_cfg_t;

    typedef struct packed {
        logic [11:0] base;
        logic [3:0]  size;
    } ebw_sel_t;

    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [1:0]  be;
        logic [23:0] addr;
    } ebw_cpu_req_t;

    typedef struct packed {
        logic        ale;
        logic        rd_n;
        logic        wr_n;
        logic        wrl_n;
        logic        wrh_n;
        logic [4:0]  ext_cs_n;
        logic [5:0]  int_cs_n;
        logic        bus16;
        logic        muxed;
        logic [23:0] addr;
    } ebw_pins_t;

    localparam ebw_pins_t PINS_IDLE = '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
        wrl_n: 1'b1, wrh_n: 1'b1, ext_cs_n: 5'h1f, int_cs_n: 6'h3f,
        bus16: 1'b0, muxed: 1'b0, addr: 24'h000000};

    typedef struct packed {
        logic [N_REGS-1:0][15:0] regs;
        logic                    awready;
        logic                    wready;
        logic                    aw_held;
        logic                    w_held;
        logic [5:0]              aw_idx;
        logic [15:0]             w_data;
        logic [1:0]              w_be;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [15:0]             rdata;
        logic [1:0]              rresp;
        logic [2:0]              rdy_sync;
        logic                    rdy_flt;
        logic [2:0][1:0]         strap_sync;
        ebw_phase_t              phase;
        ebw_cfg_t                cfg;
        logic [3:0]              win;
        logic [4:0]              cnt;
        logic                    wr;
        logic [1:0]              be;
        logic [23:0]             addr;
        logic                    err;
        logic                    done;
        ebw_pins_t               pins;
    } ebw_state_t;
endpackage

// ### rtl/ebw_window_config.sv
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - cycle waits equal fifteen minus field
// - command delay ctl clear adds one tcl
// - tristate ctl clear adds one wait
// - early write ends strobe one tcl sooner
// - bus type selects width and multiplexing
// - reset sets default active, stretch, strap type
// - stretch bit lengthens address latch strobe
// - inactive window performs no bus cycle
// - ready enable extends cycle until ready
// - read gated select follows read strobe
// - write gated select follows write strobes
// - six internal and five external configurations
// - after reset only default window selects
// - default config covers unmatched external accesses
// - matched window applies its own config
// - external window sizes 4k to 4m
// - low internal windows force a23..a20 zero
// - low internal sizes 256 bytes to 512k
// - fourth internal window uses low scheme
// - internal windows five, six decode externally
// - all bus config registers share layout
module ebw_window_config (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [7:0]              awaddr,
    input  wire logic                    awvalid,
    output logic                         awready,
    input  wire logic [31:0]             wdata,
    input  wire logic [3:0]              wstrb,
    input  wire logic                    wvalid,
    output logic                         wready,
    output logic [1:0]                   bresp,
    output logic                         bvalid,
    input  wire logic                    bready,
    input  wire logic [7:0]              araddr,
    input  wire logic                    arvalid,
    output logic                         arready,
    output logic [31:0]                  rdata,
    output logic [1:0]                   rresp,
    output logic                         rvalid,
    input  wire logic                    rready,
    input  wire ebw_pkg::ebw_cpu_req_t   cpu_req,
    output logic                         cpu_done,
    output logic                         cpu_err,
    input  wire logic                    ready_pin,
    input  wire logic [1:0]              strap_port,
    output ebw_pkg::ebw_pins_t           bus_pins
);
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    ebw_pkg::ebw_state_t st_ff;
    ebw_pkg::ebw_state_t nxt_st;

    // window hit test; low selects the first-megabyte scheme
    function automatic logic win_hit(
        input logic [23:0]        a,
        input ebw_pkg::ebw_sel_t  s,
        input logic               low
    );
        logic [11:0] m;
        logic [11:0] ab;
        logic        ok;
        m = 12'hfff << s.size;
        if (low) begin
            ab = a[19:8];
            ok = (a[23:20] == 4'h0) && (s.size <= ebw_pkg::SIZE_MAX_LOW);
        end else begin
            ab = a[23:12];
            m  = m & 12'h7ff;
            ok = s.size <= ebw_pkg::SIZE_MAX_EXT;
        end
        // bits below the window size never take part
        return ok && ((ab & m) == (s.base & m));
    endfunction

    // byte-lane merge of a register write
    function automatic logic [15:0] wmerge(
        input logic [15:0] old,
        input logic [15:0] d,
        input logic [1:0]  be,
        input logic [15:0] msk
    );
        logic [15:0] r;
        r = old;
        if (be[0]) r[7:0]  = d[7:0];
        if (be[1]) r[15:8] = d[15:8];
        return r & msk;
    endfunction

    // mask for a register index, config layout shared by all
    function automatic logic [15:0] wmask(input logic [5:0] i);
        logic [15:0] m;
        m = ebw_pkg::CFG_WMASK;
        if (i >= ebw_pkg::REG_ESEL && i < ebw_pkg::REG_ICFG) begin
            m = ebw_pkg::SEL_WMASK;
        end
        return m;
    endfunction

    // command-phase length: base plus cycle-time waits
    function automatic logic [4:0] wait_load(input ebw_pkg::ebw_cfg_t c);
        return ebw_pkg::WAIT_TOP - {1'b0, c.cycle_wait} + ebw_pkg::CMD_BASE;
    endfunction

    // -------------------------------------------------------------
    // next-state logic
    // -------------------------------------------------------------
    always_comb begin
        ebw_pkg::ebw_cfg_t c;
        ebw_pkg::ebw_cfg_t sc;
        logic [3:0]        w;
        logic [23:0]       pa;
        logic              act;
        logic              rds;
        logic              wrs;
        logic              cs;
        logic [5:0]        ri;
        c   = ebw_pkg::ebw_cfg_t'(st_ff.regs[ebw_pkg::REG_DEF]);
        sc  = ebw_pkg::ebw_cfg_t'(16'h0000);
        w   = ebw_pkg::WIN_DEF;
        pa  = 24'h000000;
        act = 1'b0;
        rds = 1'b0;
        wrs = 1'b0;
        cs  = 1'b0;
        ri  = 6'h00;
        nxt_st = st_ff;
        nxt_st.done = 1'b0;

        // ready and strap pins pass three flops, ready changes when two agree
        nxt_st.rdy_sync = {st_ff.rdy_sync[1:0], ready_pin};
        if (st_ff.rdy_sync[2] == st_ff.rdy_sync[1]) begin
            nxt_st.rdy_flt = st_ff.rdy_sync[2];
        end
        nxt_st.strap_sync = {st_ff.strap_sync[1:0], strap_port};

        // axi write: address and data taken in either order
        if (awvalid && st_ff.awready) begin
            nxt_st.awready = 1'b0;
            nxt_st.aw_held = 1'b1;
            nxt_st.aw_idx  = awaddr[7:2];
        end
        if (wvalid && st_ff.wready) begin
            nxt_st.wready = 1'b0;
            nxt_st.w_held = 1'b1;
            nxt_st.w_data = wdata[15:0];
            nxt_st.w_be   = wstrb[1:0];
        end
        if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = ebw_pkg::RESP_OKAY;
            if (st_ff.aw_idx < 6'(ebw_pkg::N_REGS)) begin
                nxt_st.regs[st_ff.aw_idx[4:0]] = wmerge(st_ff.regs[st_ff.aw_idx[4:0]],
                    st_ff.w_data, st_ff.w_be, wmask(st_ff.aw_idx));
            end else if (st_ff.aw_idx != ebw_pkg::REG_STATUS) begin
                nxt_st.bresp = ebw_pkg::RESP_SLVERR;
            end
        end
        if (st_ff.bvalid && bready) begin
            nxt_st.bvalid  = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready  = 1'b1;
        end

        // axi read: one outstanding, data registered
        if (arvalid && st_ff.arready) begin
            ri             = araddr[7:2];
            nxt_st.arready = 1'b0;
            nxt_st.rvalid  = 1'b1;
            nxt_st.rresp   = ebw_pkg::RESP_OKAY;
            nxt_st.rdata   = 16'h0000;
            if (ri < 6'(ebw_pkg::N_REGS)) begin
                nxt_st.rdata = st_ff.regs[ri[4:0]];
            end else if (ri == ebw_pkg::REG_STATUS) begin
                nxt_st.rdata = {10'h000, st_ff.err,
                    st_ff.phase != ebw_pkg::PH_IDLE, st_ff.win};
            end else begin
                nxt_st.rresp = ebw_pkg::RESP_SLVERR;
            end
        end
        if (st_ff.rvalid && rready) begin
            nxt_st.rvalid  = 1'b0;
            nxt_st.arready = 1'b1;
        end

        // window decode, lowest internal index wins, then external
        for (int i = ebw_pkg::N_EXT - 1; i >= 0; i--) begin
            sc = ebw_pkg::ebw_cfg_t'(st_ff.regs[int'(ebw_pkg::REG_WCFG) + i]);
            if (sc.bus_active && win_hit(cpu_req.addr,
                    st_ff.regs[int'(ebw_pkg::REG_ESEL) + i], 1'b0)) begin
                w = 4'(i + 1);
                c = sc;
            end
        end
        for (int i = ebw_pkg::N_INT - 1; i >= 0; i--) begin
            sc = ebw_pkg::ebw_cfg_t'(st_ff.regs[int'(ebw_pkg::REG_ICFG) + i]);
            if (sc.bus_active && win_hit(cpu_req.addr,
                    st_ff.regs[int'(ebw_pkg::REG_ISEL) + i],
                    i < ebw_pkg::N_INT_LOW)) begin
                w = ebw_pkg::WIN_INT0 + 4'(i);
                c = sc;
            end
        end

        // bus cycle sequencer, one tcl per clock
        if (st_ff.phase != ebw_pkg::PH_CMD) begin
            nxt_st.cnt = wait_load(st_ff.cfg);
        end
        unique case (st_ff.phase)
            ebw_pkg::PH_IDLE: begin
                if (cpu_req.valid) begin
                    nxt_st.win  = w;
                    nxt_st.cfg  = c;
                    nxt_st.wr   = cpu_req.wr;
                    nxt_st.be   = cpu_req.be;
                    nxt_st.addr = cpu_req.addr;
                    nxt_st.err  = !c.bus_active;
                    nxt_st.phase = c.bus_active ? ebw_pkg::PH_ALE
                                                : ebw_pkg::PH_DONE;
                end
            end
            ebw_pkg::PH_ALE: begin
                if (st_ff.cfg.ale_stretch) begin
                    nxt_st.phase = ebw_pkg::PH_ALEX;
                end else begin
                    nxt_st.phase = st_ff.cfg.cmd_dly ? ebw_pkg::PH_CMD
                                                     : ebw_pkg::PH_DLY;
                end
            end
            ebw_pkg::PH_ALEX: begin
                nxt_st.phase = st_ff.cfg.cmd_dly ? ebw_pkg::PH_CMD
                                                 : ebw_pkg::PH_DLY;
            end
            ebw_pkg::PH_DLY: begin
                nxt_st.phase = ebw_pkg::PH_CMD;
            end
            ebw_pkg::PH_CMD: begin
                if (st_ff.cnt != 5'h00) begin
                    nxt_st.cnt = st_ff.cnt - 5'h01;
                end else if (!st_ff.cfg.ready_en || st_ff.rdy_flt) begin
                    nxt_st.phase = st_ff.cfg.tri_ctl ? ebw_pkg::PH_DONE
                                                     : ebw_pkg::PH_TRI;
                end
            end
            ebw_pkg::PH_TRI: begin
                nxt_st.phase = ebw_pkg::PH_DONE;
            end
            ebw_pkg::PH_DONE: begin
                nxt_st.phase = ebw_pkg::PH_IDLE;
                nxt_st.err   = 1'b0;                          // error flag only with done
            end
        endcase
        nxt_st.done = nxt_st.phase == ebw_pkg::PH_DONE;

        // pin values for the coming tcl
        act = nxt_st.phase inside {ebw_pkg::PH_ALE, ebw_pkg::PH_ALEX,
                                   ebw_pkg::PH_DLY, ebw_pkg::PH_CMD};
        rds = (nxt_st.phase == ebw_pkg::PH_CMD) && !nxt_st.wr;
        wrs = (nxt_st.phase == ebw_pkg::PH_CMD) && nxt_st.wr &&
              !(nxt_st.cfg.early_wr && nxt_st.cnt == 5'h00);
        cs  = act;
        if (nxt_st.cfg.rd_gated && !nxt_st.wr) begin
            cs = rds;
        end
        if (nxt_st.cfg.wr_gated && nxt_st.wr) begin
            cs = wrs;
        end
        pa = nxt_st.addr;
        if (nxt_st.win >= ebw_pkg::WIN_INT0 &&
                nxt_st.win < ebw_pkg::WIN_INT0 + 4'(ebw_pkg::N_INT_LOW)) begin
            pa[23:20] = 4'h0;
        end
        nxt_st.pins          = ebw_pkg::PINS_IDLE;
        nxt_st.pins.ale      = nxt_st.phase inside {ebw_pkg::PH_ALE, ebw_pkg::PH_ALEX};
        nxt_st.pins.rd_n     = !rds;
        nxt_st.pins.wr_n     = !wrs;
        nxt_st.pins.wrl_n    = !(wrs && nxt_st.be[0] && nxt_st.cfg.bus_type[1]);
        nxt_st.pins.wrh_n    = !(wrs && nxt_st.be[1] && nxt_st.cfg.bus_type[1]);
        nxt_st.pins.bus16    = nxt_st.cfg.bus_type[1];
        nxt_st.pins.muxed    = nxt_st.cfg.bus_type[0];
        nxt_st.pins.addr     = act ? pa : 24'h000000;
        if (nxt_st.win < ebw_pkg::WIN_INT0) begin
            nxt_st.pins.ext_cs_n[nxt_st.win[2:0]] = !cs;
        end else begin
            nxt_st.pins.int_cs_n[3'(nxt_st.win - ebw_pkg::WIN_INT0)] = !cs;
        end
    end

    // -------------------------------------------------------------
    // state register, strap caught while reset is held
    // -------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff            <= '0;
            st_ff.awready    <= 1'b1;
            st_ff.wready     <= 1'b1;
            st_ff.arready    <= 1'b1;
            st_ff.phase      <= ebw_pkg::PH_IDLE;
            st_ff.pins       <= ebw_pkg::PINS_IDLE;
            st_ff.rdy_sync   <= nxt_st.rdy_sync;
            st_ff.strap_sync <= nxt_st.strap_sync;
            st_ff.regs[ebw_pkg::REG_DEF] <= ebw_pkg::RST_DEF_CFG |
                (16'(st_ff.strap_sync[2]) << ebw_pkg::BTYP_LSB);
        end else begin
            st_ff <= nxt_st;
        end
    end

    // -------------------------------------------------------------
    // outputs, all straight from the state register
    // -------------------------------------------------------------
    assign awready  = st_ff.awready;
    assign wready   = st_ff.wready;
    assign bvalid   = st_ff.bvalid;
    assign bresp    = st_ff.bresp;
    assign arready  = st_ff.arready;
    assign rvalid   = st_ff.rvalid;
    assign rresp    = st_ff.rresp;
    assign rdata    = {16'h0000, st_ff.rdata};
    assign cpu_done = st_ff.done;
    assign cpu_err  = st_ff.err;
    assign bus_pins = st_ff.pins;
endmodule // ebw_window_config

// ### verif/ebw_ext_mem.sv
`timescale 1ns/1ps
// --------------------
// far-side peripheral
// --------------------
module ebw_ext_mem (
    input  wire logic               aclk,
    input  wire ebw_pkg::ebw_pins_t bus_pins,
    input  wire logic [3:0]         delay,
    output logic                    ready_pin
);
    logic [3:0] cnt_ff = 4'h0;
    logic       busy;
    assign busy = !(bus_pins.rd_n && bus_pins.wr_n);
    // count strobe cycles
    always_ff @(posedge aclk) begin
        cnt_ff <= busy ? cnt_ff + 4'(cnt_ff != 4'hf) : 4'h0;
    end
    // ready after the chosen delay, released line reads not ready
    assign ready_pin = busy && (cnt_ff >= delay);
endmodule // ebw_ext_mem

// ### verif/ebw_window_config_assertions.sv
`timescale 1ns/1ps
// --------------------
// bus cycle checker
// --------------------
module ebw_window_config_chk (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire ebw_pkg::ebw_cpu_req_t cpu_req,
    input wire logic                  cpu_done,
    input wire logic                  cpu_err,
    input wire ebw_pkg::ebw_pins_t    bus_pins
);
    logic [10:0] cs_on;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // active chip selects, internal windows above external ones
    assign cs_on = ~{bus_pins.int_cs_n, bus_pins.ext_cs_n};
    one_select_a: assert property ($onehot0(cs_on))
        else $error("two chip selects active");
    low_int_addr_a: assert property (|cs_on[8:5] |-> bus_pins.addr[23:20] == 4'h0)
        else $error("high address lines set in low window");
    err_no_cycle_a: assert property (cpu_err |-> cpu_done && cs_on == 11'h000)
        else $error("error without done or with chip select");
    ale_no_cmd_a: assert property (bus_pins.ale |-> bus_pins.rd_n && bus_pins.wr_n)
        else $error("command during address latch");
    cmd_min_len_a: assert property ($fell(bus_pins.rd_n) |=> !bus_pins.rd_n)
        else $error("read command shorter than two cycles");
    done_pulse_a: assert property (cpu_done |=> !cpu_done)
        else $error("done longer than one cycle");
    byte_strobe_a: assert property (!(bus_pins.wrl_n && bus_pins.wrh_n) |-> bus_pins.bus16)
        else $error("byte strobe on narrow bus");
    cmd_has_cs_a: assert property (!(bus_pins.rd_n && bus_pins.wr_n) |-> cs_on != 11'h000)
        else $error("command without chip select");
    take_done_a: assert property ($rose(cpu_req.valid) |-> ##[1:64] cpu_done)
        else $error("access not finished in time");
endmodule // ebw_window_config_chk
bind ebw_window_config ebw_window_config_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .cpu_req(cpu_req), .cpu_done(cpu_done),
    .cpu_err(cpu_err), .bus_pins(bus_pins)
);

// ### verif/tb_top.sv
`timescale 1ns/1ps
// --------------------
// register and bus cycle bench
// --------------------
module tb_top;
    typedef struct packed {
        logic        err;
        logic [31:0] val;
        logic [7:0]  slack;
    } ebw_note_t;
    logic                  aclk = 1'h0;
    logic                  aresetn = 1'h0;
    logic [7:0]            awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]           wdata = 32'h0, rdata;
    logic [3:0]            wstrb = 4'h0, delay = 4'h0;
    logic                  awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic                  arvalid = 1'h0, rready = 1'h0;
    logic                  awready, wready, bvalid, arready, rvalid;
    logic                  cpu_done, cpu_err, ready_pin;
    logic [1:0]            bresp, rresp, strap = 2'h0, typ = 2'h0;
    ebw_pkg::ebw_cpu_req_t cpu_req = '0;
    ebw_pkg::ebw_pins_t    bus_pins;
    ebw_note_t             q[$];
    ebw_note_t             n;
    logic [10:0]           cs_seen = 11'h000;
    logic [15:0]           def;
    logic [15:0]           cfgs[4] = '{16'h040f, 16'h0475, 16'hc797, 16'h85ca};
    int                    cyc = 0, err_count = 0, samples_checked = 0;

    always #50 aclk = ~aclk;

    ebw_window_config dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .cpu_req(cpu_req),
        .cpu_done(cpu_done), .cpu_err(cpu_err), .ready_pin(ready_pin),
        .strap_port(strap), .bus_pins(bus_pins)
    );
    ebw_ext_mem u_mem (.aclk(aclk), .bus_pins(bus_pins), .delay(delay), .ready_pin(ready_pin));

    task automatic test_done();
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic bad, input string m);
        samples_checked++;
        if (bad !== 1'h0) begin
            err_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    // register write, both channels offered together
    task automatic axw(input logic [7:0] a, input logic [15:0] d, input logic e);
        q.push_back(ebw_note_t'{e, 32'h0, 8'h0});
        awaddr <= a;
        wdata <= {16'($urandom), d};
        wstrb <= {2'($urandom), 2'h3};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        bready <= 1'h0;
        @(posedge aclk);
    endtask

    // register read with expected data
    task automatic axr(input logic [7:0] a, input logic [15:0] d, input logic e);
        q.push_back(ebw_note_t'{e, {16'h0, d}, 8'h0});
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rready <= 1'h0;
        @(posedge aclk);
    endtask

    // one cpu access; expected length from the governing configuration
    task automatic cpu(input logic [23:0] a, input logic [15:0] c, input logic [10:0] cs,
                       input logic [7:0] sl);
        ebw_pkg::ebw_cfg_t f;
        logic [7:0]        len;
        f = c;
        len = 8'h13 + 8'(f.ale_stretch) + 8'(!f.cmd_dly) - 8'(f.cycle_wait) + 8'(!f.tri_ctl);
        if (f.bus_active) q.push_back(ebw_note_t'{1'h0, {13'h0, cs, f.bus_type, len}, sl});
        else q.push_back(ebw_note_t'{1'h1, 32'h1, 8'h0});
        cpu_req <= '{1'h1, 1'($urandom), 2'($urandom_range(3, 1)), a};
        do @(posedge aclk); while (cpu_done !== 1'h1);
        cpu_req.valid <= 1'h0;
        @(posedge aclk);
    endtask

    // compare each result with the oldest note
    always @(posedge aclk) begin
        if (aresetn) begin
            if (cpu_req.valid && !cpu_done) cyc++;
            cs_seen = cs_seen | ~{bus_pins.int_cs_n, bus_pins.ext_cs_n};
            if (bus_pins.ale) typ = {bus_pins.bus16, bus_pins.muxed};
            if (bvalid && bready) begin
                n = q.pop_front();
                chk(bresp !== (n.err ? ebw_pkg::RESP_SLVERR : ebw_pkg::RESP_OKAY),
                    "bresp");
            end
            if (rvalid && rready) begin
                n = q.pop_front();
                chk(rresp !== (n.err ? ebw_pkg::RESP_SLVERR : ebw_pkg::RESP_OKAY)
                    || rdata !== n.val, "read data");
            end
            if (cpu_done) begin
                n = q.pop_front();
                chk(cpu_err !== n.err || {cs_seen, typ} !== n.val[20:8]
                    || cyc < n.val[7:0] || cyc > n.val[7:0] + n.slack, "bus cycle");
                cyc = 0;
                cs_seen = 11'h000;
                typ = 2'h0;
            end
        end
    end

    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge aclk);
        err_count++;
        test_done();
    end

    initial begin
        void'($urandom(32'hc711));
        strap = 2'($urandom);
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        def = ebw_pkg::RST_DEF_CFG | (16'(strap) << ebw_pkg::BTYP_LSB);
        axr(8'h00, def, 1'h0);
        for (int i = 1; i < 21; i++) axr(8'(i * 4), 16'h0000, 1'h0);
        axr(8'h58, 16'h0000, 1'h1);
        axw(8'h58, 16'hffff, 1'h1);
        for (int i = 0; i < 5; i++) begin
            axw(8'(i * 4), 16'hffff, 1'h0);
            axr(8'(i * 4), ebw_pkg::CFG_WMASK, 1'h0);
            axw(8'(i * 4), (i == 0) ? def : 16'h0000, 1'h0);
        end
        cpu(24'($urandom), def, 11'h001, 8'h0);
        axw(8'h14, 16'h0121, 1'h0);
        foreach (cfgs[i]) begin
            axw(8'h04, cfgs[i], 1'h0);
            cpu({1'($urandom), 10'h009, 1'($urandom), 12'($urandom)}, cfgs[i], 11'h002, 8'h0);
        end
        cpu({1'($urandom), 11'h014, 12'($urandom)}, def, 11'h001, 8'h0);
        axw(8'h14, 16'h012b, 1'h0);
        cpu({1'($urandom), 11'h012, 12'($urandom)}, def, 11'h001, 8'h0);
        axw(8'h14, 16'h0121, 1'h0);
        axw(8'h00, 16'h0000, 1'h0);
        cpu({1'($urandom), 11'h700, 12'($urandom)}, 16'h0000, 11'h000, 8'h0);
        axw(8'h00, def, 1'h0);
        axw(8'h24, 16'h3450, 1'h0);
        axw(8'h3c, 16'h0475, 1'h0);
        cpu({12'h034, 4'h5, 8'($urandom)}, 16'h0475, 11'h020, 8'h0);
        cpu({12'h134, 4'h5, 8'($urandom)}, def, 11'h001, 8'h0);
        axw(8'h34, 16'h0120, 1'h0);
        axw(8'h4c, 16'h040f, 1'h0);
        cpu({1'($urandom), 11'h012, 12'($urandom)}, 16'h040f, 11'h200, 8'h0);
        axw(8'h04, 16'h1408, 1'h0);
        delay <= 4'($urandom_range(15, 10));
        cpu({1'($urandom), 11'h013, 12'($urandom)}, 16'h1408, 11'h002, 8'h10);
        repeat (4) @(posedge aclk);
        chk(q.size() != 0, "result missing");
        test_done();
    end
endmodule // tb_top
